// [verilog/gp_timer_pkg.sv]
package gp_timer_pkg;

  // Configuration register values
  localparam logic [2:0] CFG_RTC = 3'h1;
  localparam logic [2:0] CFG_16BIT = 3'h4;

  // Timer mode field encodings
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;

  // Event field encodings
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;

  // Register offsets; per-half registers of the second half sit HALF_STEP above
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CTL = 8'h0c;
  localparam logic [7:0] OFF_IMR = 8'h18;
  localparam logic [7:0] OFF_RIS = 8'h1c;
  localparam logic [7:0] OFF_MIS = 8'h20;
  localparam logic [7:0] OFF_ICR = 8'h24;
  localparam logic [7:0] OFF_ILR = 8'h28;
  localparam logic [7:0] OFF_MATCH = 8'h30;
  localparam logic [7:0] OFF_PR = 8'h38;
  localparam logic [7:0] OFF_VAL = 8'h48;
  localparam logic [7:0] HALF_STEP = 8'h04;

  // Status bit layout: half flags at HALF_FLAGS*h, RTC flag alone
  localparam int RIS_TOUT = 0;
  localparam int RIS_CMATCH = 1;
  localparam int RIS_CEVENT = 2;
  localparam int RIS_RTC = 3;
  localparam int HALF_FLAGS = 4;
  localparam int CTL_BITS = 8;

  // Reset and load values
  localparam logic [15:0] CNT_RESET = 16'hffff;
  localparam logic [15:0] ILR_RESET = 16'hffff;
  localparam logic [31:0] RTC_PRELOAD = 32'h00000001;
  localparam logic [31:0] RTC_WRAP = 32'h00000000;

  // RTC input and tick rates
  localparam int RTC_CLK_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;

  typedef struct packed {
    logic ams;
    logic cmr;
    logic [1:0] mode;
  } half_mode_type;

  typedef struct packed {
    logic spare;
    logic inv;
    logic ote;
    logic rtc_en;
    logic [1:0] evt;
    logic stall;
    logic en;
  } half_ctl_type;

  typedef struct packed {
    logic cevent;
    logic cmatch;
    logic tout;
  } half_flags_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_type;

endpackage : gp_timer_pkg

// [verilog/gp_timer_module.sv]
`timescale 1ns/10ps

module gp_timer_module #(
  parameter int RTC_DIV = gp_timer_pkg::RTC_CLK_HZ / gp_timer_pkg::RTC_TICK_HZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire gp_timer_pkg::bus_req_type bus_req,
  output logic [31:0] rdata,
  input wire logic [1:0] ccp_in,
  output logic [1:0] ccp_out,
  output logic [1:0] ccp_oe,
  output logic [1:0] trigger,
  output logic irq
);

  logic [2:0] cfg;
  gp_timer_pkg::half_mode_type mode [2];
  gp_timer_pkg::half_ctl_type ctl [2];
  logic [15:0] ilr [2];
  logic [15:0] match [2];
  logic [15:0] cnt [2];
  logic [15:0] capt [2];
  logic [15:0] val [2];
  logic [7:0] pr [2];
  logic [7:0] pre [2];
  logic [7:0] ris;
  logic [7:0] imr;
  logic [7:0] mis;
  logic [7:0] next_ris;
  logic [1:0] pin_q;
  logic [1:0] en_clr;
  logic [1:0] ilr_wr;
  logic [1:0] run;
  gp_timer_pkg::half_flags_type fset [2];
  logic [31:0] rtc_div;
  logic [31:0] rtc_cnt;
  logic [31:0] rtc_match;
  logic [31:0] next_rtc;
  logic rtc_mode;
  logic m16;
  logic rtc_run;
  logic rtc_tick;
  logic rtc_hit;
  logic rtc_load;
  logic cfg_wr;

  assign rtc_mode = cfg == gp_timer_pkg::CFG_RTC;
  assign m16 = cfg == gp_timer_pkg::CFG_16BIT;
  assign cfg_wr = bus_req.wr && bus_req.addr == gp_timer_pkg::OFF_CFG;
  assign rtc_load = cfg_wr && bus_req.wdata[2:0] == gp_timer_pkg::CFG_RTC && !rtc_mode;

  assign rtc_cnt = {cnt[1], cnt[0]};
  assign rtc_match = {match[1], match[0]};
  assign rtc_run = rtc_mode && ctl[0].en && (ctl[0].rtc_en || !(ctl[0].stall || ctl[1].stall));
  // 1 Hz tick from pin clock
  assign rtc_tick = rtc_run && ccp_in[0] && !pin_q[0] && rtc_div == 32'(RTC_DIV - 1);
  assign rtc_hit = rtc_tick && rtc_cnt == rtc_match;
  assign next_rtc = rtc_hit ? gp_timer_pkg::RTC_WRAP : rtc_cnt + 32'h1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_q <= 2'h0;
    end else begin
      pin_q <= ccp_in;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rtc_div <= 32'h0;
    end else if (!rtc_run || rtc_load) begin
      rtc_div <= 32'h0;
    end else if (ccp_in[0] && !pin_q[0]) begin
      rtc_div <= (rtc_div == 32'(RTC_DIV - 1)) ? 32'h0 : rtc_div + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg <= 3'h0;
      imr <= 8'h0;
    end else begin
      if (cfg_wr) begin
        cfg <= bus_req.wdata[2:0];
      end
      if (bus_req.wr && bus_req.addr == gp_timer_pkg::OFF_IMR) begin
        imr <= bus_req.wdata[7:0];
      end
    end
  end

  // Hardware disable wins over a software write in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl[0] <= '0;
      ctl[1] <= '0;
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (bus_req.wr && bus_req.addr == gp_timer_pkg::OFF_CTL) begin
          ctl[h] <= bus_req.wdata[h*gp_timer_pkg::CTL_BITS +: gp_timer_pkg::CTL_BITS];
        end
        if (en_clr[h]) begin
          ctl[h].en <= 1'b0;
        end
      end
    end
  end

  // Set wins over clear in the same cycle
  always_comb begin
    next_ris = ris;
    if (bus_req.wr && bus_req.addr == gp_timer_pkg::OFF_ICR) begin
      next_ris = next_ris & ~bus_req.wdata[7:0];
    end
    next_ris[gp_timer_pkg::RIS_RTC] = next_ris[gp_timer_pkg::RIS_RTC] | rtc_hit;
    for (int h = 0; h < 2; h++) begin
      next_ris[h*gp_timer_pkg::HALF_FLAGS +: 3] = next_ris[h*gp_timer_pkg::HALF_FLAGS +: 3] | fset[h];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ris <= 8'h0;
    end else begin
      ris <= next_ris;
    end
  end

  assign mis = ris & imr;
  assign irq = |mis;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        gp_timer_pkg::OFF_CFG: rdata <= {29'h0, cfg};
        gp_timer_pkg::OFF_MODE: rdata <= {28'h0, mode[0]};
        gp_timer_pkg::OFF_MODE + gp_timer_pkg::HALF_STEP: rdata <= {28'h0, mode[1]};
        gp_timer_pkg::OFF_CTL: rdata <= {16'h0, ctl[1], ctl[0]};
        gp_timer_pkg::OFF_IMR: rdata <= {24'h0, imr};
        gp_timer_pkg::OFF_RIS: rdata <= {24'h0, ris};
        gp_timer_pkg::OFF_MIS: rdata <= {24'h0, mis};
        gp_timer_pkg::OFF_ILR: rdata <= {16'h0, ilr[0]};
        gp_timer_pkg::OFF_ILR + gp_timer_pkg::HALF_STEP: rdata <= {16'h0, ilr[1]};
        gp_timer_pkg::OFF_MATCH: rdata <= {16'h0, match[0]};
        gp_timer_pkg::OFF_MATCH + gp_timer_pkg::HALF_STEP: rdata <= {16'h0, match[1]};
        gp_timer_pkg::OFF_PR: rdata <= {24'h0, pr[0]};
        gp_timer_pkg::OFF_PR + gp_timer_pkg::HALF_STEP: rdata <= {24'h0, pr[1]};
        gp_timer_pkg::OFF_VAL: rdata <= rtc_mode ? rtc_cnt : {16'h0, val[0]};
        gp_timer_pkg::OFF_VAL + gp_timer_pkg::HALF_STEP: rdata <= {16'h0, val[1]};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  for (genvar h = 0; h < 2; h++) begin : g_half
    localparam logic [7:0] HOFF = 8'(h) * gp_timer_pkg::HALF_STEP;
    gp_timer_pkg::half_mode_type m;
    gp_timer_pkg::half_ctl_type c;
    logic rise;
    logic fall;
    logic is_tmr;
    logic is_pwm;
    logic is_cnt;
    logic is_time;
    logic cnt_edge;
    logic time_edge;
    logic step;
    logic lvl;
    logic pin_r;
    logic trig_r;
    logic [15:0] dec;

    assign m = mode[h];
    assign c = ctl[h];
    assign rise = ccp_in[h] && !pin_q[h];
    assign fall = !ccp_in[h] && pin_q[h];
    assign dec = cnt[h] - 16'h1;
    assign is_tmr = !m.ams && (m.mode == gp_timer_pkg::MODE_ONESHOT ||
                               m.mode == gp_timer_pkg::MODE_PERIODIC);
    assign is_pwm = m.ams && !m.cmr && m.mode == gp_timer_pkg::MODE_PERIODIC;
    assign is_cnt = !m.ams && !m.cmr && m.mode == gp_timer_pkg::MODE_CAPTURE;
    assign is_time = !m.ams && m.cmr && m.mode == gp_timer_pkg::MODE_CAPTURE;
    assign cnt_edge = (c.evt == gp_timer_pkg::EV_RISE && rise) ||
                      (c.evt == gp_timer_pkg::EV_FALL && fall) ||
                      (c.evt == gp_timer_pkg::EV_BOTH && (rise || fall));
    // one polarity only, both reads as rising
    assign time_edge = (c.evt == gp_timer_pkg::EV_FALL) ? fall : rise;
    assign run[h] = m16 && c.en && !c.stall;
    assign step = is_tmr ? pre[h] == 8'h0 : (is_pwm || is_time);
    assign ilr_wr[h] = bus_req.wr && bus_req.addr == gp_timer_pkg::OFF_ILR + HOFF;
    assign fset[h].tout = run[h] && is_tmr && step && cnt[h] == 16'h0;
    assign fset[h].cmatch = run[h] && is_cnt && cnt_edge && dec == match[h];
    assign fset[h].cevent = run[h] && is_time && time_edge;
    assign en_clr[h] = (fset[h].tout && m.mode == gp_timer_pkg::MODE_ONESHOT) || fset[h].cmatch;
    assign val[h] = is_time ? capt[h] : cnt[h];
    assign ccp_out[h] = pin_r;
    assign ccp_oe[h] = m16 && is_pwm;
    assign trigger[h] = trig_r;

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        mode[h] <= '0;
        ilr[h] <= gp_timer_pkg::ILR_RESET;
        match[h] <= 16'h0;
        pr[h] <= 8'h0;
      end else if (bus_req.wr) begin
        if (bus_req.addr == gp_timer_pkg::OFF_MODE + HOFF) begin
          mode[h] <= bus_req.wdata[3:0];
        end
        if (ilr_wr[h]) begin
          ilr[h] <= bus_req.wdata[15:0];
        end
        if (rtc_mode && bus_req.addr == gp_timer_pkg::OFF_MATCH) begin
          match[h] <= bus_req.wdata[h*16 +: 16];
        end else if (bus_req.addr == gp_timer_pkg::OFF_MATCH + HOFF) begin
          match[h] <= bus_req.wdata[15:0];
        end
        if (bus_req.addr == gp_timer_pkg::OFF_PR + HOFF) begin
          pr[h] <= bus_req.wdata[7:0];
        end
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        cnt[h] <= gp_timer_pkg::CNT_RESET;
      end else if (rtc_load) begin
        cnt[h] <= gp_timer_pkg::RTC_PRELOAD[h*16 +: 16];
      end else if (rtc_mode) begin
        if (rtc_tick) begin
          cnt[h] <= next_rtc[h*16 +: 16];
        end
      end else if (ilr_wr[h]) begin
        cnt[h] <= bus_req.wdata[15:0];
      end else if (run[h]) begin
        if (is_cnt) begin
          if (cnt_edge) begin
            cnt[h] <= fset[h].cmatch ? ilr[h] : dec;
          end
        end else if (step) begin
          cnt[h] <= (cnt[h] == 16'h0) ? ilr[h] : dec;
        end
      end
    end

    // prescale divides by value plus one
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        pre[h] <= 8'h0;
      end else if (!c.en) begin
        pre[h] <= pr[h];
      end else if (run[h] && is_tmr) begin
        pre[h] <= (pre[h] == 8'h0) ? pr[h] : pre[h] - 8'h1;
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        capt[h] <= gp_timer_pkg::CNT_RESET;
      end else if (fset[h].cevent) begin
        capt[h] <= cnt[h];
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        lvl <= 1'b0;
        pin_r <= 1'b0;
      end else begin
        if (run[h] && is_pwm && cnt[h] == ilr[h]) begin
          lvl <= 1'b1;
          pin_r <= !c.inv;
        end else if (run[h] && is_pwm && cnt[h] == match[h]) begin
          lvl <= 1'b0;
          pin_r <= c.inv;
        end else begin
          pin_r <= lvl ^ c.inv;
        end
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        trig_r <= 1'b0;
      end else begin
        trig_r <= fset[h].tout && c.ote;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_rtc_wrapped;
    ##1 (rtc_cnt == gp_timer_pkg::RTC_WRAP) ##0 ris[gp_timer_pkg::RIS_RTC];
  endsequence
  sequence s_em_done;
    ##1 !ctl[0].en ##0 (cnt[0] == $past(ilr[0])) ##0 ris[gp_timer_pkg::RIS_CMATCH];
  endsequence

  property p_rtc_preload;
    rtc_load |=> rtc_cnt == gp_timer_pkg::RTC_PRELOAD;
  endproperty
  a_rtc_preload: assert property (p_rtc_preload) else $error("rtc preload wrong");
  property p_rtc_wrap;
    rtc_hit |-> s_rtc_wrapped;
  endproperty
  a_rtc_wrap: assert property (p_rtc_wrap) else $error("rtc wrap or flag wrong");
  property p_rtc_up;
    rtc_tick && !rtc_hit |=> rtc_cnt == $past(rtc_cnt) + 32'h1;
  endproperty
  a_rtc_up: assert property (p_rtc_up) else $error("rtc did not count up");
  // Divider must still advance on pin edges while a stall bit is set (needs RTC_DIV above one)
  property p_rtc_override;
    rtc_mode && ctl[0].en && ctl[0].rtc_en && (ctl[0].stall || ctl[1].stall) &&
      ccp_in[0] && !pin_q[0] |=> rtc_div != $past(rtc_div);
  endproperty
  a_rtc_override: assert property (p_rtc_override) else $error("rtc stalled");
  property p_em_done;
    fset[0].cmatch && !ilr_wr[0] |-> s_em_done;
  endproperty
  a_em_done: assert property (p_em_done) else $error("edge count end wrong");
  property p_tout_reload;
    fset[0].tout && !ilr_wr[0] |=> cnt[0] == $past(ilr[0]) && ris[gp_timer_pkg::RIS_TOUT];
  endproperty
  a_tout_reload: assert property (p_tout_reload) else $error("timeout reload wrong");
  property p_ilr_take;
    m16 && ilr_wr[0] |=> cnt[0] == $past(bus_req.wdata[15:0]);
  endproperty
  a_ilr_take: assert property (p_ilr_take) else $error("load not taken");
  property p_stall;
    m16 && ctl[0].stall && !ilr_wr[0] |=> $stable(cnt[0]);
  endproperty
  a_stall: assert property (p_stall) else $error("stalled counter moved");
  property p_capture;
    fset[0].cevent |=> capt[0] == $past(cnt[0]) && ris[gp_timer_pkg::RIS_CEVENT];
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");
  property p_pwm_quiet;
    g_half[1].is_pwm |=> (ris[gp_timer_pkg::HALF_FLAGS +: 3] &
      ~$past(ris[gp_timer_pkg::HALF_FLAGS +: 3])) == 3'h0;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm raised a flag");

endmodule : gp_timer_module

// [sim/ccp_source.sv]
`timescale 1ns/10ps

module ccp_source (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] pulse_req,
  input wire logic rtc_run,
  output logic [1:0] ccp
);
  logic [1:0] hold_a;
  logic [1:0] hold_b;
  logic [2:0] div;
  logic rtc_clk;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_a <= 2'h0;
      hold_b <= 2'h0;
    end else begin
      hold_a <= pulse_req[0] ? 2'h3 : (hold_a != 2'h0 ? hold_a - 2'h1 : 2'h0);
      hold_b <= pulse_req[1] ? 2'h3 : (hold_b != 2'h0 ? hold_b - 2'h1 : 2'h0);
    end
  end

  // slow clock source, scaled rate; stands low when stopped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div <= 3'h0;
      rtc_clk <= 1'b0;
    end else if (!rtc_run) begin
      div <= 3'h0;
      rtc_clk <= 1'b0;
    end else begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
        rtc_clk <= ~rtc_clk;
      end
    end
  end

  assign ccp[0] = (hold_a != 2'h0) | rtc_clk;
  assign ccp[1] = hold_b != 2'h0;
endmodule : ccp_source

// [sim/timer_rtc_capture_pwm_modes_tb.sv]
`timescale 1ns/10ps

module timer_rtc_capture_pwm_modes_tb;
  localparam logic [7:0] CFG = gp_timer_pkg::OFF_CFG;
  localparam logic [7:0] MODE = gp_timer_pkg::OFF_MODE;
  localparam logic [7:0] CTL = gp_timer_pkg::OFF_CTL;
  localparam logic [7:0] IMR = gp_timer_pkg::OFF_IMR;
  localparam logic [7:0] RIS = gp_timer_pkg::OFF_RIS;
  localparam logic [7:0] ICR = gp_timer_pkg::OFF_ICR;
  localparam logic [7:0] ILR = gp_timer_pkg::OFF_ILR;
  localparam logic [7:0] MAT = gp_timer_pkg::OFF_MATCH;
  localparam logic [7:0] PR = gp_timer_pkg::OFF_PR;
  localparam logic [7:0] VAL = gp_timer_pkg::OFF_VAL;
  localparam logic [7:0] HS = gp_timer_pkg::HALF_STEP;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  gp_timer_pkg::bus_req_type bus_req = '0;
  logic [31:0] rdata;
  logic [1:0] ccp_in;
  logic [1:0] ccp_out;
  logic [1:0] ccp_oe;
  logic [1:0] trigger;
  logic irq;
  logic [1:0] pulse_req = 2'h0;
  logic rtc_run = 1'b0;
  logic [31:0] v;
  logic [31:0] w;
  logic [1:0] evs [3] = '{gp_timer_pkg::EV_RISE, gp_timer_pkg::EV_FALL, gp_timer_pkg::EV_BOTH};
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int trig_a = 0;

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc++;
    if (trigger[0] === 1'b1) begin
      trig_a++;
    end
  end

  gp_timer_module #(.RTC_DIV(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe),
    .trigger(trigger), .irq(irq));

  ccp_source i_src (.sys_clk(sys_clk), .rst(rst), .pulse_req(pulse_req),
    .rtc_run(rtc_run), .ccp(ccp_in));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(n, e, v);
  endtask : rchk

  task automatic pulse();
    @(posedge sys_clk);
    pulse_req[0] <= 1'b1;
    @(posedge sys_clk);
    pulse_req[0] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : pulse

  task automatic wait_trig(output int t);
    int k;
    for (k = 0; k < 100; k++) begin
      @(posedge sys_clk);
      #1;
      if (trigger[1] === 1'b1) break;
    end
    t = cyc;
  endtask : wait_trig

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #500000;
    fails++;
    final_report();
  end

  initial begin
    int t0;
    int t1;
    int hi;
    int k;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rchk("ilr reset", ILR, 32'h0000ffff);
    rchk("count reset", VAL, 32'h0000ffff);
    rchk("prescale reset", PR, 32'h0);
    rchk("unmapped", 8'hfc, 32'h0);
    $display("reset values done");
    wr(CFG, 32'h4);
    wr(MODE, 32'h1);
    wr(ILR, 32'h5);
    rchk("load taken", VAL, 32'h5);
    wr(IMR, 32'h1);
    wr(CTL, 32'h21);
    repeat (20) @(posedge sys_clk);
    chk("trigger pulses", 32'h1, trig_a);
    rchk("timeout flag", RIS, 32'h1);
    chk("irq", 32'h1, irq);
    rchk("enable cleared", CTL, 32'h20);
    rchk("reloaded", VAL, 32'h5);
    wr(ICR, 32'h1);
    rchk("flag cleared", RIS, 32'h0);
    $display("one-shot done");
    wr(MODE + HS, 32'h2);
    wr(ILR + HS, 32'h3);
    wr(PR + HS, 32'h2);
    wr(CTL, 32'h2100);
    wait_trig(t0);
    wait_trig(t1);
    chk("period", 32'd12, t1 - t0);
    wait_trig(t1);
    chk("periodic runs", 32'd12, t1 - t0 - 12);
    wr(CTL, 32'h2300);
    rd(VAL + HS, v);
    repeat (6) @(posedge sys_clk);
    rd(VAL + HS, w);
    chk("stalled", v, w);
    wr(CTL, 32'h0);
    $display("prescale and stall done");
    wr(MODE, 32'h3);
    for (k = 0; k < 3; k++) begin
      wr(ILR, 32'd10);
      wr(MAT, 32'd8);
      wr(ICR, 32'h7f);
      wr(CTL, (32'(evs[k]) << 2) | 32'h1);
      pulse();
      rd(RIS, v);
      chk("match after one pulse", 32'(evs[k] == gp_timer_pkg::EV_BOTH), 32'(v[1]));
      pulse();
      rd(RIS, v);
      chk("match flag", 32'h1, 32'(v[1]));
      rchk("edge reload", VAL, 32'd10);
      rchk("edge enable cleared", CTL, 32'(evs[k]) << 2);
    end
    $display("edge count done");
    wr(MODE, 32'h7);
    wr(ILR, 32'h0000ffff);
    wr(ICR, 32'h7f);
    wr(CTL, 32'h1);
    repeat (20) @(posedge sys_clk);
    pulse();
    rd(RIS, v);
    chk("event flag", 32'h1, 32'(v[2]));
    rd(VAL, v);
    repeat (30) @(posedge sys_clk);
    rd(VAL, w);
    chk("capture held", v, w);
    chk("counted down", 32'h1, 32'(v < 32'h0000ffff));
    wr(CTL, 32'h0);
    wr(ICR, 32'h7f);
    $display("edge time done");
    wr(MODE + HS, 32'ha);
    wr(ILR + HS, 32'd9);
    wr(MAT + HS, 32'd2);
    wr(CTL, 32'h100);
    for (k = 0; k < 2; k++) begin
      repeat (15) @(posedge sys_clk);
      hi = 0;
      repeat (20) begin
        @(posedge sys_clk);
        #1;
        if (ccp_out[1] === 1'b1) hi++;
      end
      chk("pwm high cycles", k == 0 ? 32'd14 : 32'd6, hi);
      chk("pwm drives", 32'h1, 32'(ccp_oe[1]));
      chk("pwm half a idle", 32'h0, 32'(ccp_oe[0]));
      wr(CTL, 32'h4100);
    end
    rchk("pwm no flags", RIS, 32'h0);
    wr(CTL, 32'h0);
    $display("pwm done");
    wr(CFG, 32'h1);
    rchk("rtc preload", VAL, 32'h1);
    wr(MAT, 32'h3);
    wr(IMR, 32'h8);
    wr(CTL, 32'h13);
    rtc_run <= 1'b1;
    for (k = 0; k < 500; k++) begin
      rd(RIS, v);
      if (v[3] === 1'b1) break;
    end
    chk("rtc flag despite stall", 32'h8, v);
    chk("rtc irq", 32'h1, irq);
    rchk("rtc wrap", VAL, 32'h0);
    wr(ICR, 32'h8);
    rchk("rtc flag cleared", RIS, 32'h0);
    chk("rtc irq cleared", 32'h0, irq);
    rtc_run <= 1'b0;
    $display("rtc done");
    final_report();
  end
endmodule : timer_rtc_capture_pwm_modes_tb
